/* rtl/acr_pkg.sv */
// Package for the converter control and status block: map, layouts, types
package acr_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_CONFIG_A   = 4'h0;
  localparam logic [3:0] OFS_CONFIG_B   = 4'h1;
  localparam logic [3:0] OFS_CONFIG_C   = 4'h2;
  localparam logic [3:0] OFS_FLAGS      = 4'h3;
  localparam logic [3:0] OFS_RESULT_HI  = 4'h4;
  localparam logic [3:0] OFS_RESULT_LO  = 4'h5;
  localparam logic [3:0] OFS_UPPER_HI   = 4'h6;
  localparam logic [3:0] OFS_UPPER_LO   = 4'h7;
  localparam logic [3:0] OFS_LOWER_HI   = 4'h8;
  localparam logic [3:0] OFS_LOWER_LO   = 4'h9;

  // Reset values
  localparam logic [7:0]  RST_CONFIG_A  = 8'h00;
  localparam logic [7:0]  RST_CONFIG_B  = 8'h00;
  localparam logic [7:0]  RST_CONFIG_C  = 8'h1F;
  localparam logic [2:0]  RST_FLAGS     = 3'h0;
  localparam logic [11:0] RST_RESULT    = 12'h000;
  localparam logic [3:0]  RST_UPPER_HI  = 4'hF;
  localparam logic [7:0]  RST_UPPER_LO  = 8'hFF;
  localparam logic [3:0]  RST_LOWER_HI  = 4'h0;
  localparam logic [7:0]  RST_LOWER_LO  = 8'h00;

  // Field positions
  localparam int POS_POWER_ON   = 0;
  localparam int POS_SW_START   = 1;
  localparam int POS_RES_LO     = 5;
  localparam int POS_HALVER     = 7;
  localparam int POS_EDGE_LO    = 5;
  localparam int POS_SRC_LO     = 3;
  localparam int POS_SMP_LO     = 0;
  localparam int POS_SMP2_LO    = 5;
  localparam int POS_WATCH_LO   = 0;
  localparam int POS_EOC        = 0;
  localparam int POS_WINDOW     = 1;
  localparam int POS_OVERRUN    = 2;

  // Edge and source encodings
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_FALL  = 2'h2;
  localparam logic [1:0] EDGE_BOTH  = 2'h3;
  localparam logic [1:0] SRC_SW     = 2'h0;

  // Resolution codes
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8  = 2'h2;
  localparam logic [1:0] RES_6  = 2'h3;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } acr_bus_type;

  // Converter core completion report
  typedef struct packed {
    logic        done;
    logic        last;
    logic [4:0]  channel;
    logic [11:0] value;
  } acr_core_type;

  // Valid data bits for a resolution code
  function automatic logic [11:0] res_mask(input logic [1:0] res);
    case (res)
      RES_12:  res_mask = 12'h0FFF;
      RES_10:  res_mask = 12'h03FF;
      RES_8:   res_mask = 12'h00FF;
      default: res_mask = 12'h003F;
    endcase
  endfunction

  // Sampling period in converter cycles for a three-bit code
  function automatic logic [8:0] sample_cycles(input logic [2:0] code);
    case (code)
      3'h0:    sample_cycles = 9'h004;
      3'h1:    sample_cycles = 9'h009;
      3'h2:    sample_cycles = 9'h010;
      3'h3:    sample_cycles = 9'h018;
      3'h4:    sample_cycles = 9'h030;
      3'h5:    sample_cycles = 9'h060;
      3'h6:    sample_cycles = 9'h0C0;
      default: sample_cycles = 9'h180;
    endcase
  endfunction

endpackage

/* rtl/acr_ctrl.sv */
// Converter control, watchdog, result and flag registers
//
// Notes on behaviour
// - Halver bit set gives converter clock tick every second cycle, else every cycle.
// - Edge field 01 rising, 10 falling, 11 both; 00 reserved, no edges.
// - Source 00 allows only software start; 01..11 pick external trigger 1..3.
// - Main sampling code maps 000..111 to 4..384 cycles for channels 0-23.
// - Special sampling code in bits 7:5 uses same table for special channels.
// - Five-bit watch field picks monitored channel, 11100 reference, 11101 temperature.
// - Overrun set when a conversion completes before DMA read the previous result; a bus read of the result does not count.
// - Overrun cleared by writing zero or power-down; writing one does nothing.
// - Window alert set when watched result is above upper or below lower limit.
// - Window alert cleared by writing zero or power-down; never set by software.
// - Done flag set at end; cleared by zero write, low result read, power-down.
// - In scan, done flag rises only after last channel of sequence.
// - Flag bits 7:3 and upper four bits of high bytes read zero.
// - Result high byte is read-only, bits 3:0 hold upper result bits.
// - Right aligned: 10-bit uses high bits 1:0, 8/6-bit high byte empty.
// - Low result byte holds bits 7:0, at 6-bit only bits 5:0.
// - Upper limit split hi 11:8 and lo 7:0, reset 0x0F and 0xFF.
// - Lower limit split hi 11:8 and lo 7:0, both reset 0x00.
// - Limit bits used follow resolution alignment like the result.
// - Third config register resets to 0x1F, watch field all ones.
// - Resolution 00 12-bit, 01 10-bit, 10 8-bit, 11 6-bit.
// - Power-on bit low is power-down and clears flags; high wakes converter.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps

module acr_ctrl
  import acr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Register port
  input  wire acr_bus_type  bus_req,
  output logic [7:0]        bus_rdata,
  // Converter core
  input  wire acr_core_type core_rep,
  input  wire logic         dma_read,
  output logic              conv_start,
  output logic              conv_clk_tick,
  output logic              power_on,
  output logic [1:0]        resolution,
  output logic [8:0]        smp_main,
  output logic [8:0]        smp_special,
  // External trigger pins, asynchronous
  input  wire logic [2:0]   ext_trig
);

  // Whole state of the block
  typedef struct packed {
    logic [7:0]  cfg_a;
    logic [7:0]  cfg_b;
    logic [7:0]  cfg_c;
    logic [2:0]  flags;
    logic [11:0] result;
    logic [3:0]  upper_hi;
    logic [7:0]  upper_lo;
    logic [3:0]  lower_hi;
    logic [7:0]  lower_lo;
    logic        busy;
    logic        pending;
    logic        tick;
    logic        start;
    logic [7:0]  rdata;
    logic [2:0]  trig_ff1;
    logic [2:0]  trig_ff2;
    logic [2:0]  trig_prev;
    logic [8:0]  smp_a;
    logic [8:0]  smp_b;
  } acr_state_type;

  acr_state_type s;
  acr_state_type next_s;

  // Decoded fields
  logic        pwr;
  logic [1:0]  res;
  logic [1:0]  edge_sel;
  logic [1:0]  src_sel;
  logic [4:0]  watch_ch;
  logic [11:0] mask;
  logic [11:0] upper_val;
  logic [11:0] lower_val;
  logic [11:0] core_val;
  logic        done_ok;
  logic        wd_hit;

  // Configuration decode and watchdog compare
  always_comb begin
    pwr       = s.cfg_a[POS_POWER_ON];
    res       = s.cfg_a[POS_RES_LO +: 2];
    edge_sel  = s.cfg_b[POS_EDGE_LO +: 2];
    src_sel   = s.cfg_b[POS_SRC_LO +: 2];
    watch_ch  = s.cfg_c[POS_WATCH_LO +: 5];
    mask      = res_mask(res);
    upper_val = {s.upper_hi, s.upper_lo} & mask;
    lower_val = {s.lower_hi, s.lower_lo} & mask;
    core_val  = core_rep.value & mask;
    done_ok   = core_rep.done && pwr;
    wd_hit    = done_ok && (core_rep.channel == watch_ch) &&
                ((core_val > upper_val) || (core_val < lower_val));
  end

  // Next-state logic: bus, flags, triggers, clock tick
  always_comb begin
    logic       wr_flags;
    logic       trig_lvl;
    logic       trig_old;
    logic       trigger_edge_select;
    logic       sw_go;
    logic       set_eoc;
    logic       set_ovr;
    wr_flags  = bus_req.wr && (bus_req.addr == OFS_FLAGS);
    trig_lvl  = 1'b0;
    trig_old  = 1'b0;
    trigger_edge_select = 1'b0;
    sw_go     = 1'b0;
    set_eoc   = 1'b0;
    set_ovr   = 1'b0;
    next_s    = s;
    next_s.start = 1'b0;

    // Pin synchroniser, first stage read only by second
    next_s.trig_ff1  = ext_trig;
    next_s.trig_ff2  = s.trig_ff1;
    next_s.trig_prev = s.trig_ff2;

    // Selected trigger and its active edge
    if (src_sel != SRC_SW) begin
      trig_lvl = s.trig_ff2[src_sel - 2'd1];
      trig_old = s.trig_prev[src_sel - 2'd1];
    end
    case (edge_sel)
      EDGE_RISE: trigger_edge_select = trig_lvl && !trig_old;
      EDGE_FALL: trigger_edge_select = !trig_lvl && trig_old;
      EDGE_BOTH: trigger_edge_select = trig_lvl != trig_old;
      default:   trigger_edge_select = 1'b0;
    endcase
    sw_go = bus_req.wr && (bus_req.addr == OFS_CONFIG_A) &&
            bus_req.wdata[POS_SW_START] && (src_sel == SRC_SW);

    // Start only when awake and idle; a start during a conversion is dropped
    if (pwr && !s.busy && (sw_go || trigger_edge_select)) begin
      next_s.start = 1'b1;
      next_s.busy  = 1'b1;
    end
    if (done_ok || !pwr) begin
      next_s.busy = 1'b0;
    end

    // Result capture, masked to the active resolution
    if (done_ok) begin
      next_s.result = core_val;
    end

    // Unread-result tracking for overrun
    set_ovr = done_ok && s.pending;
    if (dma_read) begin
      next_s.pending = 1'b0;
    end
    if (done_ok) begin
      next_s.pending = 1'b1;
    end

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_CONFIG_A: next_s.cfg_a = bus_req.wdata & 8'h61;
        OFS_CONFIG_B: next_s.cfg_b = bus_req.wdata;
        OFS_CONFIG_C: next_s.cfg_c = bus_req.wdata;
        OFS_UPPER_HI: next_s.upper_hi = bus_req.wdata[3:0];
        OFS_UPPER_LO: next_s.upper_lo = bus_req.wdata;
        OFS_LOWER_HI: next_s.lower_hi = bus_req.wdata[3:0];
        OFS_LOWER_LO: next_s.lower_lo = bus_req.wdata;
        default:      next_s.cfg_a = next_s.cfg_a;
      endcase
    end

    // Flags: software only clears, hardware set wins over the clear
    if (wr_flags) begin
      next_s.flags = s.flags & bus_req.wdata[2:0];
    end
    if (bus_req.rd && (bus_req.addr == OFS_RESULT_LO)) begin
      next_s.flags[POS_EOC] = 1'b0;
    end
    set_eoc = done_ok && core_rep.last;
    if (set_eoc) begin
      next_s.flags[POS_EOC] = 1'b1;
    end
    if (wd_hit) begin
      next_s.flags[POS_WINDOW] = 1'b1;
    end
    if (set_ovr) begin
      next_s.flags[POS_OVERRUN] = 1'b1;
    end
    // Power-down holds every flag cleared
    if (!pwr) begin
      next_s.flags   = RST_FLAGS;
      next_s.pending = 1'b0;
    end

    // Converter clock tick, halved by toggling
    if (s.cfg_b[POS_HALVER]) begin
      next_s.tick = !s.tick;
    end else begin
      next_s.tick = 1'b1;
    end

    // Sampling periods, looked up from the new configuration
    next_s.smp_a = sample_cycles(next_s.cfg_b[POS_SMP_LO +: 3]);
    next_s.smp_b = sample_cycles(next_s.cfg_c[POS_SMP2_LO +: 3]);

    // Read data, valid in the cycle after the strobe only
    next_s.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_CONFIG_A:  next_s.rdata = s.cfg_a;
        OFS_CONFIG_B:  next_s.rdata = s.cfg_b;
        OFS_CONFIG_C:  next_s.rdata = s.cfg_c;
        OFS_FLAGS:     next_s.rdata = {5'h00, s.flags};
        OFS_RESULT_HI: next_s.rdata = {4'h0, s.result[11:8]};
        OFS_RESULT_LO: next_s.rdata = s.result[7:0];
        OFS_UPPER_HI:  next_s.rdata = {4'h0, s.upper_hi};
        OFS_UPPER_LO:  next_s.rdata = s.upper_lo;
        OFS_LOWER_HI:  next_s.rdata = {4'h0, s.lower_hi};
        OFS_LOWER_LO:  next_s.rdata = s.lower_lo;
        default:       next_s.rdata = 8'h00;
      endcase
    end
  end

  // State register; the enable freezes everything
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.cfg_a    <= RST_CONFIG_A;
      s.cfg_b    <= RST_CONFIG_B;
      s.cfg_c    <= RST_CONFIG_C;
      s.upper_hi <= RST_UPPER_HI;
      s.upper_lo <= RST_UPPER_LO;
      s.lower_hi <= RST_LOWER_HI;
      s.lower_lo <= RST_LOWER_LO;
      s.result   <= RST_RESULT;
      s.smp_a    <= 9'h004;
      s.smp_b    <= 9'h004;
      s.tick     <= 1'b1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign bus_rdata     = s.rdata;
  assign conv_start    = s.start;
  assign conv_clk_tick = s.tick;
  assign power_on      = s.cfg_a[POS_POWER_ON];
  assign resolution    = s.cfg_a[POS_RES_LO +: 2];
  assign smp_main      = s.smp_a;
  assign smp_special   = s.smp_b;

  // Checks
  halver_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && s.cfg_b[POS_HALVER] |=> conv_clk_tick == !$past(conv_clk_tick))
    else $error("halved tick did not toggle");
  full_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !s.cfg_b[POS_HALVER] |=> conv_clk_tick)
    else $error("undivided tick missing");
  overrun_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && pwr && core_rep.done && s.pending |=> s.flags[POS_OVERRUN])
    else $error("overrun not flagged");
  overrun_one_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && bus_req.wr && bus_req.addr == OFS_FLAGS && !s.flags[POS_OVERRUN]
    && !(core_rep.done && s.pending) |=> !s.flags[POS_OVERRUN])
    else $error("software set overrun");
  window_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && wd_hit |=> s.flags[POS_WINDOW])
    else $error("window alert not flagged");
  pdown_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !pwr |=> s.flags == 3'h0)
    else $error("flags survive power-down");
  scan_done_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && core_rep.done && !core_rep.last && !s.flags[POS_EOC] |=> !s.flags[POS_EOC])
    else $error("done flag raised mid-sequence");
  low_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && bus_req.rd && bus_req.addr == OFS_RESULT_LO
    && !(core_rep.done && core_rep.last) |=> !s.flags[POS_EOC])
    else $error("low byte read kept done flag");
  flag_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && bus_req.rd && bus_req.addr == OFS_FLAGS |=> bus_rdata[7:3] == 5'h00)
    else $error("reserved flag bits nonzero");
  busy_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && s.busy |=> !conv_start)
    else $error("start issued while busy");
  start_power_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !pwr |=> !conv_start)
    else $error("start issued while powered down");
  edge_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && edge_sel == 2'h0 && src_sel != SRC_SW |=> !conv_start)
    else $error("start from reserved edge code");
  window_sw_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && bus_req.wr && bus_req.addr == OFS_FLAGS && !s.flags[POS_WINDOW]
    && !wd_hit |=> !s.flags[POS_WINDOW])
    else $error("software set window alert");
  eoc_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && done_ok && core_rep.last |=> s.flags[POS_EOC])
    else $error("done flag not raised");
  result_hi_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && bus_req.rd && bus_req.addr == OFS_RESULT_HI |=> bus_rdata[7:4] == 4'h0)
    else $error("reserved result bits nonzero");
  result_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && done_ok |=> (s.result & ~res_mask($past(res))) == 12'h000)
    else $error("result wider than resolution");

  overrun_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    s.flags[POS_OVERRUN]);
  window_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    s.flags[POS_WINDOW]);
  trig_start_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    conv_start && src_sel != SRC_SW);
  scan_mid_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    core_rep.done && !core_rep.last && pwr);
  eoc_clear_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    s.flags[POS_EOC] ##1 !s.flags[POS_EOC]);

endmodule // acr_ctrl

/* verification/acr_core_model.sv */
// Behavioural converter core answering each start taken while idle with a completion report
`timescale 1ns/100ps

module acr_core_model
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Start pulse from the control block
  input  wire logic         conv_start,
  // Conversion time and result chosen by the bench
  input  wire logic [3:0]   dly,
  input  wire logic [11:0]  val,
  input  wire logic [4:0]   chan,
  input  wire logic         last,
  // Completion report
  output acr_core_type      core_rep
);
  logic [3:0]  cnt;
  logic        run;
  logic        done;
  logic [11:0] junk;

  // Count the conversion time down; a start while running is dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 4'h0;
      run  <= 1'b0;
      done <= 1'b0;
      junk <= 12'h000;
    end else begin
      junk <= junk + 12'h0A5;
      done <= run && (cnt == 4'h0);
      if (conv_start && !run) begin
        run <= 1'b1;
        cnt <= dly;
      end else if (run && cnt == 4'h0) begin
        run <= 1'b0;
      end else if (run) begin
        cnt <= cnt - 4'h1;
      end
    end
  end

  // Moving pattern outside the done cycle, so stale data cannot pass
  assign core_rep = done ? {1'b1, last, chan, val} : {1'b0, junk[0], junk[4:0], junk};
endmodule // acr_core_model

/* verification/tb.sv */
// Self-checking bench for the converter control and status block
`timescale 1ns/100ps

module tb;
  import acr_pkg::*;
  logic         clk_sys;
  logic         rst_n;
  logic         clk_en;
  acr_bus_type  bus_req;
  logic [7:0]   bus_rdata;
  acr_core_type core_rep;
  logic         dma_read;
  logic         conv_start;
  logic         tick;
  logic [8:0]   smp_m;
  logic [8:0]   smp_s;
  logic [2:0]   ext_trig;
  logic [3:0]   m_dly;
  logic [11:0]  m_val;
  logic [4:0]   m_ch;
  logic         m_last;
  logic [7:0]   cfg_a;
  logic         t0;
  logic         pwr_o;
  logic [1:0]   res_o;
  int           err_count;
  int           n_tests;
  int           cyc;
  int           nstart;
  int           n0;
  // Expected reset image of offsets 0x0 to 0x9 plus one unmapped place
  localparam logic [7:0] RSTV [11] = '{8'h00, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h00,
                                       8'h0F, 8'hFF, 8'h00, 8'h00, 8'h00};
  localparam logic [8:0] SMP [8] = '{9'h004, 9'h009, 9'h010, 9'h018, 9'h030, 9'h060,
                                     9'h0C0, 9'h180};
  localparam logic [3:0] WA [7] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'h3, 4'h4, 4'hA};
  localparam logic [7:0] WE [7] = '{8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h00, 8'h00, 8'h00};
  localparam logic [11:0] VW [5] = '{12'h900, 12'h800, 12'h100, 12'h0FF, 12'h900};
  localparam logic [7:0] FE [5] = '{8'h03, 8'h01, 8'h01, 8'h03, 8'h01};
  localparam logic [4:0] CH [4] = '{5'h00, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [7:0] RH [4] = '{8'h0F, 8'h03, 8'h00, 8'h00};
  localparam logic [7:0] RL [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F};

  acr_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .core_rep(core_rep), .dma_read(dma_read), .conv_start(conv_start),
    .conv_clk_tick(tick), .power_on(pwr_o), .resolution(res_o), .smp_main(smp_m),
    .smp_special(smp_s),
    .ext_trig(ext_trig));
  acr_core_model cm (.clk_sys(clk_sys), .rst_n(rst_n), .conv_start(conv_start), .dly(m_dly),
    .val(m_val), .chan(m_ch), .last(m_last), .core_rep(core_rep));

  // Clock, 10 ns period
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Start counter and hang guard, far above the less than two thousand cycles needed
  always @(posedge clk_sys) begin
    nstart <= nstart + (conv_start === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus_req <= '{1'b0, 1'b0, a, d};
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    bus_req <= '{1'b0, 1'b0, a, 8'h00};
    #1 chk($sformatf("reg %h", a), {4'h0, exp}, {4'h0, bus_rdata});
  endtask

  // Software start, wait for the report, optionally let DMA take the result
  task automatic conv(input logic [11:0] v, input logic [4:0] c, input logic l, input logic dm);
    int i;
    m_val <= v;
    m_ch <= c;
    m_last <= l;
    wr(OFS_CONFIG_A, cfg_a | 8'h02);
    i = 0;
    while (core_rep.done !== 1'b1 && i < 40) begin
      @(negedge clk_sys);
      i++;
    end
    chk("conversion done", 12'h001, {11'h0, core_rep.done});
    @(posedge clk_sys);
    dma_read <= dm;
    @(posedge clk_sys);
    dma_read <= 1'b0;
  endtask

  task automatic pulse(input logic [2:0] m, input int hold);
    @(posedge clk_sys);
    ext_trig <= m;
    repeat (hold) @(posedge clk_sys);
    ext_trig <= 3'h0;
    repeat (14) @(posedge clk_sys);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    bus_req = '0;
    dma_read = 1'b0;
    ext_trig = 3'h0;
    m_dly = 4'h2;
    m_val = 12'h000;
    m_ch = 5'h00;
    m_last = 1'b1;
    cfg_a = 8'h01;
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    nstart = 0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 0; a < 11; a++) rchk(a[3:0], RSTV[a]);
    for (int k = 0; k < 7; k++) begin
      wr(WA[k], 8'hFF);
      rchk(WA[k], WE[k]);
    end
    wr(OFS_UPPER_HI, 8'h08);
    wr(OFS_UPPER_LO, 8'h00);
    wr(OFS_LOWER_HI, 8'h01);
    wr(OFS_LOWER_LO, 8'h00);
    // Enable low: the write must be dropped
    clk_en <= 1'b0;
    wr(OFS_UPPER_LO, 8'h55);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rchk(OFS_UPPER_LO, 8'h00);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CONFIG_B, 8'(c));
      #1 chk("main sample", {3'h0, SMP[c]}, {3'h0, smp_m});
      wr(OFS_CONFIG_C, {3'(c), 5'h05});
      #1 chk("special sample", {3'h0, SMP[c]}, {3'h0, smp_s});
      rchk(OFS_CONFIG_C, {3'(c), 5'h05});
    end
    wr(OFS_CONFIG_B, 8'h80);
    @(negedge clk_sys) t0 = tick;
    @(negedge clk_sys) chk("tick halved", {11'h0, ~t0}, {11'h0, tick});
    wr(OFS_CONFIG_B, 8'h00);
    // Old halver setting still toggles once at the write edge
    repeat (2) @(negedge clk_sys);
    chk("tick full", 12'h001, {11'h0, tick});
    $display("test sampling and clock done");
    wr(OFS_CONFIG_A, cfg_a);
    conv(12'h5BC, 5'h05, 1'b1, 1'b1);
    rchk(OFS_FLAGS, 8'h01);
    rchk(OFS_RESULT_HI, 8'h05);
    rchk(OFS_RESULT_LO, 8'hBC);
    rchk(OFS_FLAGS, 8'h00);
    conv(12'h123, 5'h05, 1'b1, 1'b0);
    rchk(OFS_FLAGS, 8'h01);
    conv(12'h456, 5'h05, 1'b1, 1'b1);
    rchk(OFS_FLAGS, 8'h05);
    wr(OFS_FLAGS, 8'h03);
    rchk(OFS_FLAGS, 8'h01);
    wr(OFS_FLAGS, 8'h00);
    rchk(OFS_FLAGS, 8'h00);
    conv(12'h456, 5'h05, 1'b0, 1'b1);
    rchk(OFS_FLAGS, 8'h00);
    conv(12'h456, 5'h05, 1'b1, 1'b0);
    conv(12'h900, 5'h05, 1'b1, 1'b1);
    rchk(OFS_FLAGS, 8'h07);
    wr(OFS_CONFIG_A, 8'h00);
    #1 chk("power", 12'h000, {11'h0, pwr_o});
    rchk(OFS_FLAGS, 8'h00);
    wr(OFS_CONFIG_A, cfg_a);
    $display("test flags done");
    foreach (CH[j]) begin
      wr(OFS_CONFIG_C, {3'h0, CH[j]});
      for (int k = 0; k < 5; k++) begin
        wr(OFS_FLAGS, 8'h00);
        conv(VW[k], (k == 4) ? (CH[j] ^ 5'h01) : CH[j], 1'b1, 1'b1);
        rchk(OFS_FLAGS, FE[k]);
      end
    end
    wr(OFS_CONFIG_C, 8'h01);
    for (int r = 0; r < 4; r++) begin
      cfg_a = {1'b0, 2'(r), 5'h01};
      wr(OFS_CONFIG_A, cfg_a);
      #1 chk("resolution", {10'h0, 2'(r)}, {10'h0, res_o});
      conv(12'hFFF, 5'h05, 1'b1, 1'b1);
      rchk(OFS_RESULT_HI, RH[r]);
      rchk(OFS_RESULT_LO, RL[r]);
    end
    wr(OFS_CONFIG_C, 8'h05);
    wr(OFS_UPPER_HI, 8'h0F);
    wr(OFS_UPPER_LO, 8'h10);
    wr(OFS_LOWER_HI, 8'h00);
    wr(OFS_FLAGS, 8'h00);
    conv(12'h020, 5'h05, 1'b1, 1'b1);
    rchk(OFS_FLAGS, 8'h03);
    cfg_a = 8'h61;
    wr(OFS_CONFIG_A, cfg_a);
    wr(OFS_UPPER_LO, 8'hFF);
    wr(OFS_LOWER_LO, 8'h50);
    wr(OFS_FLAGS, 8'h00);
    conv(12'h018, 5'h05, 1'b1, 1'b1);
    rchk(OFS_FLAGS, 8'h01);
    $display("test watchdog and alignment done");
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 4; e++) begin
        wr(OFS_CONFIG_B, {1'b0, 2'(e), 2'(s), 3'h0});
        n0 = nstart;
        pulse((s == 0) ? 3'h7 : ~(3'h1 << (s - 1)), 14);
        chk("starts by other pins", 12'h000, 12'(nstart - n0));
        pulse((s == 0) ? 3'h0 : (3'h1 << (s - 1)), 14);
        chk("starts", (s == 0 || e == 0) ? 12'h000 : ((e == 3) ? 12'h002 : 12'h001),
            12'(nstart - n0));
      end
    end
    m_dly <= 4'hF;
    wr(OFS_CONFIG_B, 8'h78);
    n0 = nstart;
    pulse(3'h4, 3);
    chk("start while busy", 12'h001, 12'(nstart - n0));
    $display("test triggers done");
    results();
  end
endmodule // tb
